// ===== core/dual_dac_update_control.sv
// register file and update scheduling for two 12-bit converter channels
`timescale 1ns/100ps

// Operation
// [RQ1] control bit 7 enables channel, else shutdown
// [RQ2] disabled channel output held high impedance
// [RQ3] unsigned 12-bit code 0x000 to 0xFFF
// [RQ4] mode 00: high byte write loads latch
// [RQ5] low byte write only stored in mode 00
// [RQ6] modes 01/10/11 select timer 3/4/2 overflow
// [RQ7] timer modes hold writes until selected overflow
// [RQ8] software writes low byte before high byte
// [RQ9] 8-bit use: preset low, write high only
// [RQ10] format 000: high[3:0] plus whole low byte
// [RQ11] format 001: high[4:0] plus low[7:1]
// [RQ12] format 010: high[5:0] plus low[7:2]
// [RQ13] format 011: high[6:0] plus low[7:3]
// [RQ14] format 1xx: whole high plus low[7:4]
// [RQ15] control bits 6:5 read zero, ignore writes
// [RQ16] three-bit format field picks five alignments
// [RQ17] second channel identical with own registers
// [RQ18] software sets reference bias enable first
// [RQ19] format applied at transfer; idle reload unchanged
module dual_dac_update_control (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  sfrPage,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic        sfrWrite,
    input  wire logic        sfrRead,
    input  wire logic [7:0]  sfrWriteData,
    output logic [7:0]       sfrReadData,
    output logic             sfrReadValid,
    output logic             sfrHit,
    input  wire logic        timer2Overflow,
    input  wire logic        timer3Overflow,
    input  wire logic        timer4Overflow,
    output logic [11:0]      chanACode,
    output logic             chanAEnable,
    output logic             chanAOutDrive_n,
    output logic [11:0]      chanBCode,
    output logic             chanBEnable,
    output logic             chanBOutDrive_n
);

    // per-channel software-visible registers, index 0 is channel A
    logic [7:0] dataLow_q  [dac_pkg::CHANNELS];
    logic [7:0] dataLow_d  [dac_pkg::CHANNELS];
    logic [7:0] dataHigh_q [dac_pkg::CHANNELS];
    logic [7:0] dataHigh_d [dac_pkg::CHANNELS];
    logic [7:0] control_q  [dac_pkg::CHANNELS];
    logic [7:0] control_d  [dac_pkg::CHANNELS];
    logic       loadNow    [dac_pkg::CHANNELS];
    logic [11:0] latchCode [dac_pkg::CHANNELS];
    logic       latchEn    [dac_pkg::CHANNELS];
    logic       latchDrv_n [dac_pkg::CHANNELS];

    logic [7:0] readData_q;
    logic [7:0] readData_d;
    logic       readValid_q;
    logic       readValid_d;
    logic       hit_q;
    logic       hit_d;

    // channel selected by the current page, and whether the page is ours
    function automatic logic page_is_chan(input logic [7:0] page, input int ch);
        logic r;
        r = 1'b0;
        if (ch == 0) begin
            r = (page == dac_pkg::PAGE_CHAN_A);
        end else begin
            r = (page == dac_pkg::PAGE_CHAN_B);
        end
        return r;
    endfunction : page_is_chan

    // overflow pulse chosen by the update-mode field
    function automatic logic mode_trigger(input logic [1:0] modeBits,
                                          input logic t2,
                                          input logic t3,
                                          input logic t4);
        dac_pkg::update_mode_t m;
        logic r;
        m = dac_pkg::update_mode_t'(modeBits);
        r = 1'b0;
        case (m)
            dac_pkg::MODE_TIMER3: r = t3;                                   // [RQ6]
            dac_pkg::MODE_TIMER4: r = t4;                                   // [RQ6]
            dac_pkg::MODE_TIMER2: r = t2;                                   // [RQ6]
            default:              r = 1'b0;
        endcase
        return r;
    endfunction : mode_trigger

    // register writes and latch-load decisions for both channels
    always_comb begin
        logic                  sel;
        logic                  highWrite;
        logic [1:0]            modeBits;
        dac_pkg::update_mode_t mode;
        sel       = 1'b0;
        highWrite = 1'b0;
        modeBits  = 2'b00;
        mode      = dac_pkg::MODE_ON_WRITE;
        for (int ch = 0; ch < dac_pkg::CHANNELS; ch++) begin            // [RQ17]
            dataLow_d[ch]  = dataLow_q[ch];
            dataHigh_d[ch] = dataHigh_q[ch];
            control_d[ch]  = control_q[ch];
            sel       = sfrWrite && page_is_chan(sfrPage, ch);
            highWrite = 1'b0;
            if (sel && (sfrAddr == dac_pkg::ADDR_DATA_LOW)) begin
                dataLow_d[ch] = sfrWriteData;                               // [RQ5] [RQ9]
            end else if (sel && (sfrAddr == dac_pkg::ADDR_DATA_HIGH)) begin
                dataHigh_d[ch] = sfrWriteData;
                highWrite      = 1'b1;
            end else if (sel && (sfrAddr == dac_pkg::ADDR_CONTROL)) begin
                control_d[ch] = sfrWriteData & dac_pkg::CONTROL_MASK;      // [RQ15]
            end
            // mode in force is the one stored before this cycle's write
            modeBits = control_q[ch][dac_pkg::MODE_MSB:dac_pkg::MODE_LSB];
            mode     = dac_pkg::update_mode_t'(modeBits);
            if (mode == dac_pkg::MODE_ON_WRITE) begin
                loadNow[ch] = highWrite;                                    // [RQ4] [RQ8]
            end else begin
                // data writes only held; selected overflow copies the pair
                loadNow[ch] = mode_trigger(modeBits, timer2Overflow,
                                           timer3Overflow, timer4Overflow); // [RQ7]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int ch = 0; ch < dac_pkg::CHANNELS; ch++) begin
                dataLow_q[ch]  <= dac_pkg::RESET_DATA_LOW;
                dataHigh_q[ch] <= dac_pkg::RESET_DATA_HIGH;
                control_q[ch]  <= dac_pkg::RESET_CONTROL;
            end
        end else if (ce) begin
            for (int ch = 0; ch < dac_pkg::CHANNELS; ch++) begin
                dataLow_q[ch]  <= dataLow_d[ch];
                dataHigh_q[ch] <= dataHigh_d[ch];
                control_q[ch]  <= control_d[ch];
            end
        end
    end

    // read path: answer one cycle after the read strobe
    always_comb begin
        int chSel;
        chSel       = 0;
        readData_d  = dac_pkg::READ_UNMAPPED;
        readValid_d = sfrRead;
        hit_d       = 1'b0;
        if (page_is_chan(sfrPage, 1)) begin
            chSel = 1;
        end
        if ((sfrRead || sfrWrite) && (page_is_chan(sfrPage, 0)
                                      || page_is_chan(sfrPage, 1))) begin
            if (sfrAddr == dac_pkg::ADDR_DATA_LOW) begin
                hit_d      = 1'b1;
                readData_d = sfrRead ? dataLow_q[chSel] : dac_pkg::READ_UNMAPPED;
            end else if (sfrAddr == dac_pkg::ADDR_DATA_HIGH) begin
                hit_d      = 1'b1;
                readData_d = sfrRead ? dataHigh_q[chSel] : dac_pkg::READ_UNMAPPED;
            end else if (sfrAddr == dac_pkg::ADDR_CONTROL) begin
                hit_d      = 1'b1;
                readData_d = sfrRead ? (control_q[chSel] & dac_pkg::CONTROL_MASK)
                                     : dac_pkg::READ_UNMAPPED;            // [RQ15]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readData_q  <= dac_pkg::READ_UNMAPPED;
            readValid_q <= 1'b0;
            hit_q       <= 1'b0;
        end else if (ce) begin
            readData_q  <= readData_d;
            readValid_q <= readValid_d;
            hit_q       <= hit_d;
        end
    end

    // latch takes this cycle's new data so a load sees the fresh write
    for (genvar g = 0; g < dac_pkg::CHANNELS; g++) begin : gChan
        dac_channel_latch uLatch (
            .clk        (clk),
            .rst_n      (rst_n),
            .ce         (ce),
            .dataHigh   (dataHigh_d[g]),
            .dataLow    (dataLow_d[g]),
            .dataFormat (control_q[g][dac_pkg::FORMAT_MSB:dac_pkg::FORMAT_LSB]), // [RQ16] [RQ10] [RQ11] [RQ12] [RQ13] [RQ14]
            .loadNow    (loadNow[g]),
            .enable     (control_q[g][dac_pkg::ENABLE_BIT]),             // [RQ1]
            .code       (latchCode[g]),
            .outEnable  (latchEn[g]),
            .outDrive_n (latchDrv_n[g])
        );
    end

    assign sfrReadData     = readData_q;
    assign sfrReadValid    = readValid_q;
    assign sfrHit          = hit_q;
    assign chanACode       = latchCode[0];
    assign chanAEnable     = latchEn[0];
    assign chanAOutDrive_n = latchDrv_n[0];                                 // [RQ2]
    assign chanBCode       = latchCode[1];
    assign chanBEnable     = latchEn[1];
    assign chanBOutDrive_n = latchDrv_n[1];                                 // [RQ2]

endmodule : dual_dac_update_control

// ===== core/dac_pkg.sv
// constants, types and helpers shared by the dual converter control
package dac_pkg;

    localparam logic [7:0] ADDR_DATA_LOW   = 8'hd2;
    localparam logic [7:0] ADDR_DATA_HIGH  = 8'hd3;
    localparam logic [7:0] ADDR_CONTROL    = 8'hd4;
    localparam logic [7:0] PAGE_CHAN_A     = 8'h00;
    localparam logic [7:0] PAGE_CHAN_B     = 8'h01;

    localparam int         ENABLE_BIT      = 7;
    localparam int         MODE_MSB        = 4;
    localparam int         MODE_LSB        = 3;
    localparam int         FORMAT_MSB      = 2;
    localparam int         FORMAT_LSB      = 0;
    localparam logic [7:0] CONTROL_MASK    = 8'h9f;

    localparam logic [7:0]  RESET_DATA_LOW  = 8'h00;
    localparam logic [7:0]  RESET_DATA_HIGH = 8'h00;
    localparam logic [7:0]  RESET_CONTROL   = 8'h00;
    localparam logic [11:0] RESET_CODE      = 12'h000;
    localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

    localparam int         CHANNELS        = 2;

    typedef enum logic [1:0] {
        MODE_ON_WRITE,
        MODE_TIMER3,
        MODE_TIMER4,
        MODE_TIMER2
    } update_mode_t;

    typedef logic [11:0] code_t;

    // places the 12-bit word according to the three-bit format field
    function automatic code_t align_word(input logic [7:0] high,
                                         input logic [7:0] low,
                                         input logic [2:0] fmt);
        code_t w;
        w = {high[3:0], low[7:0]};
        if (fmt[2]) begin
            w = {high[7:0], low[7:4]};
        end else begin
            case (fmt[1:0])
                2'b00:   w = {high[3:0], low[7:0]};
                2'b01:   w = {high[4:0], low[7:1]};
                2'b10:   w = {high[5:0], low[7:2]};
                default: w = {high[6:0], low[7:3]};
            endcase
        end
        return w;
    endfunction : align_word

endpackage : dac_pkg

// ===== core/dac_channel_latch.sv
// one channel's input latch, word alignment and output drive control
`timescale 1ns/100ps
module dac_channel_latch (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  dataHigh,
    input  wire logic [7:0]  dataLow,
    input  wire logic [2:0]  dataFormat,
    input  wire logic        loadNow,
    input  wire logic        enable,
    output logic [11:0]      code,
    output logic             outEnable,
    output logic             outDrive_n
);

    logic [11:0] code_q;
    logic [11:0] code_d;
    logic        outEnable_q;
    logic        outEnable_d;
    logic        outDrive_n_q;
    logic        outDrive_n_d;

    always_comb begin
        code_d       = code_q;
        outEnable_d  = enable;                                              // [RQ1]
        outDrive_n_d = ~enable;                                             // [RQ2]
        if (loadNow) begin
            // alignment applied at transfer; reload of same data is a no-op
            code_d = dac_pkg::align_word(dataHigh, dataLow, dataFormat);  // [RQ19] [RQ3]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q       <= dac_pkg::RESET_CODE;
            outEnable_q  <= 1'b0;
            outDrive_n_q <= 1'b1;
        end else if (ce) begin
            code_q       <= code_d;
            outEnable_q  <= outEnable_d;
            outDrive_n_q <= outDrive_n_d;
        end
    end

    assign code       = code_q;
    assign outEnable  = outEnable_q;
    assign outDrive_n = outDrive_n_q;

endmodule : dac_channel_latch

// ===== testbench/dual_dac_update_control_properties.sv
// port assertions for the dual converter control
`timescale 1ns/100ps
module dual_dac_update_control_properties (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [7:0]  sfrPage,
    input wire logic [7:0]  sfrAddr,
    input wire logic        sfrWrite,
    input wire logic        sfrRead,
    input wire logic [7:0]  sfrWriteData,
    input wire logic [7:0]  sfrReadData,
    input wire logic        sfrReadValid,
    input wire logic        sfrHit,
    input wire logic        timer2Overflow,
    input wire logic        timer3Overflow,
    input wire logic        timer4Overflow,
    input wire logic [11:0] chanACode,
    input wire logic        chanAEnable,
    input wire logic        chanAOutDrive_n,
    input wire logic [11:0] chanBCode,
    input wire logic        chanBEnable,
    input wire logic        chanBOutDrive_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire anyTimer = timer2Overflow | timer3Overflow | timer4Overflow;
    wire highWrite = sfrWrite && sfrAddr == dac_pkg::ADDR_DATA_HIGH;
    property p_a_drive; chanAOutDrive_n == !chanAEnable; endproperty
    a_a_drive: assert property (p_a_drive) else $error("a drive mismatch");
    property p_b_drive; chanBOutDrive_n == !chanBEnable; endproperty
    a_b_drive: assert property (p_b_drive) else $error("b drive mismatch");
    property p_a_hold; !(highWrite || anyTimer) |=> $stable(chanACode); endproperty
    a_a_hold: assert property (p_a_hold) else $error("a code moved");
    property p_b_hold; !(highWrite || anyTimer) |=> $stable(chanBCode); endproperty
    a_b_hold: assert property (p_b_hold) else $error("b code moved");
    property p_a_enable;
        ce && sfrWrite && sfrPage == dac_pkg::PAGE_CHAN_A && sfrAddr == dac_pkg::ADDR_CONTROL
            ##1 ce |=> chanAEnable == $past(sfrWriteData[7], 2);
    endproperty
    a_a_enable: assert property (p_a_enable) else $error("a enable wrong");
    property p_ctrl_read;
        ce && sfrRead && sfrAddr == dac_pkg::ADDR_CONTROL |=> sfrReadValid && !sfrReadData[6:5];
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");
    property p_unmapped; ce && (sfrRead || sfrWrite) && sfrPage > 8'h01 |=> !sfrHit; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped hit");
    property p_valid_pulse; ce && !sfrRead |=> !sfrReadValid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("stray read valid");
endmodule : dual_dac_update_control_properties

bind dual_dac_update_control dual_dac_update_control_properties chk (.clk, .rst_n, .ce,
    .sfrPage, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData, .sfrReadData, .sfrReadValid,
    .sfrHit, .timer2Overflow, .timer3Overflow, .timer4Overflow, .chanACode, .chanAEnable,
    .chanAOutDrive_n, .chanBCode, .chanBEnable, .chanBOutDrive_n);

// ===== testbench/sfr_master_model.sv
// processor core model driving the register bus
`timescale 1ns/100ps
module sfr_master_model (
    input  wire logic clk,
    output logic [7:0] sfrPage,
    output logic [7:0] sfrAddr,
    output logic       sfrWrite,
    output logic       sfrRead,
    output logic [7:0] sfrWriteData
);
    // reference bias is set outside this block before use
    initial begin
        {sfrPage, sfrAddr, sfrWrite, sfrRead, sfrWriteData} = '0;
    end
    // one bus cycle per call; idle cycles show inverted lines
    task automatic put(input logic w, rd, input logic [7:0] p, a, d);
        @(negedge clk);
        sfrWrite <= w;
        sfrRead <= rd;
        sfrPage <= p;
        sfrAddr <= a;
        sfrWriteData <= d;
    endtask : put
endmodule : sfr_master_model

// ===== testbench/dual_dac_update_control_tb.sv
// self-checking bench for the dual converter control
`timescale 1ns/100ps
module dual_dac_update_control_tb;
    localparam logic [7:0] L = dac_pkg::ADDR_DATA_LOW;
    localparam logic [7:0] H = dac_pkg::ADDR_DATA_HIGH;
    localparam logic [7:0] C = dac_pkg::ADDR_CONTROL;
    logic clk = 1'b0;
    logic rst_n, ce, sfrWrite, sfrRead, sfrReadValid, sfrHit, chanAEnable, chanBEnable;
    logic qh [$];
    logic timer2Overflow, timer3Overflow, timer4Overflow, chanAOutDrive_n, chanBOutDrive_n;
    logic [7:0] sfrPage, sfrAddr, sfrWriteData, sfrReadData, hi [2], lo [2], ct [2], qr [$];
    logic [11:0] chanACode, chanBCode, pa, pb, ex [2], qa [$], qb [$];
    int n_fail, samples_checked;
    dual_dac_update_control uut (.clk, .rst_n, .ce, .sfrPage, .sfrAddr, .sfrWrite, .sfrRead,
        .sfrWriteData, .sfrReadData, .sfrReadValid, .sfrHit, .timer2Overflow, .timer3Overflow,
        .timer4Overflow, .chanACode, .chanAEnable, .chanAOutDrive_n, .chanBCode, .chanBEnable,
        .chanBOutDrive_n);
    sfr_master_model cpu (.clk, .sfrPage, .sfrAddr, .sfrWrite, .sfrRead, .sfrWriteData);
    function automatic logic [11:0] al(input logic [7:0] h, l, input logic [2:0] f);
        if (f[2]) return {h, l[7:4]};
        case (f[1:0])
            2'h0: return {h[3:0], l};
            2'h1: return {h[4:0], l[7:1]};
            2'h2: return {h[5:0], l[7:2]};
            default: return {h[6:0], l[7:3]};
        endcase
    endfunction : al
    task automatic chk(input string nm, input logic [11:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chkf(input string nm, input logic e, g);
        chk(nm, {11'h0, e}, {11'h0, g});
    endtask : chkf
    task automatic load(input int c);
        logic [11:0] n;
        n = al(hi[c], lo[c], ct[c][2:0]);
        if (n !== ex[c] && c == 0) qa.push_back(n);
        if (n !== ex[c] && c == 1) qb.push_back(n);
        ex[c] = n;
    endtask : load
    task automatic w(input int c, input logic [7:0] a, d);
        cpu.put(1'b1, 1'b0, 8'(c), a, d);
        if (a == L) lo[c] = d;
        if (a == H) hi[c] = d;
        if (a == H && ct[c][4:3] == 2'h0) load(c);
        if (a == C) ct[c] = d & 8'h9f;
    endtask : w
    task automatic r(input int c, input logic [7:0] a);
        cpu.put(1'b0, 1'b1, 8'(c), a, ~sfrWriteData);
        if (c > 1 || a < L || a > C) qr.push_back(8'h00);
        else qr.push_back(a == L ? lo[c] : a == H ? hi[c] : ct[c]);
        qh.push_back(!(c > 1 || a < L || a > C));
    endtask : r
    task automatic idle(input int n);
        repeat (n) cpu.put(1'b0, 1'b0, ~sfrPage, ~sfrAddr, ~sfrWriteData);
    endtask : idle
    task automatic tick(input int k);
        idle(1);
        {timer2Overflow, timer3Overflow, timer4Overflow} <= {k == 2, k == 3, k == 4};
        for (int c = 0; c < 2; c++) if (ct[c][4:3] == (k == 2 ? 2'h3 : 2'(k - 2))) load(c);
        idle(1);
        {timer2Overflow, timer3Overflow, timer4Overflow} <= 3'h0;
    endtask : tick
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    always @(negedge clk) begin
        if (sfrReadValid === 1'b1) begin
            chk("read", qr.size() ? 12'(qr.pop_front()) : 'x, {4'h0, sfrReadData});
            chkf("hit", qh.size() ? qh.pop_front() : 1'bx, sfrHit);
        end
        if (chanACode !== pa) chk("code a", qa.size() ? qa.pop_front() : 'x, chanACode);
        if (chanBCode !== pb) chk("code b", qb.size() ? qb.pop_front() : 'x, chanBCode);
        pa = chanACode;
        pb = chanBCode;
    end
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        {rst_n, timer2Overflow, timer3Overflow, timer4Overflow, pa, pb} = '0;
        ce = 1'b1;
        hi = '{default: 8'h00};
        lo = '{default: 8'h00};
        ct = '{default: 8'h00};
        ex = '{default: 12'h000};
        void'($urandom(32'h7940));
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (int c = 0; c < 3; c++) for (int a = 0; a < 5; a++) r(c, 8'hd1 + 8'(a));
        for (int c = 0; c < 2; c++) begin
            w(c, C, 8'hff);
            r(c, C);
            idle(2);
            chkf("enable", 1'b1, c ? chanBEnable : chanAEnable);
            chkf("drive_n", 1'b0, c ? chanBOutDrive_n : chanAOutDrive_n);
            w(c, C, 8'h00);
            idle(2);
            chkf("drive_n off", 1'b1, c ? chanBOutDrive_n : chanAOutDrive_n);
        end
        for (int f = 0; f < 8; f++) for (int c = 0; c < 2; c++) begin
            w(c, C, 8'h80 | 8'(f));
            w(c, L, f == 7 ? 8'hff : 8'($urandom)); // low first
            w(c, H, f == 7 ? 8'hff : 8'($urandom));
        end
        w(0, L, 8'h00);
        repeat (3) w(0, H, 8'($urandom));
        for (int m = 1; m < 4; m++) begin
            for (int c = 0; c < 2; c++) begin
                w(c, C, {3'h4, 2'(m), 3'($urandom)});
                w(c, L, 8'($urandom));
                w(c, H, 8'($urandom));
                r(c, H);
            end
            repeat (2) for (int k = 2; k < 5; k++) tick(k);
        end
        ce = 1'b0;
        cpu.put(1'b1, 1'b0, 8'h00, C, 8'h00); // frozen write must not land
        idle(1);
        ce = 1'b1;
        r(0, C);
        idle(4);
        chk("pending", 12'h000, 12'(qa.size() + qb.size() + qr.size() + qh.size()));
        end_sim();
    end
endmodule : dual_dac_update_control_tb
